// ===== icc_pkg.sv
// Package of constants for the input capture channel block
package icc_pkg;
  // Channel count and widths
  localparam int NUM_CH    = 4;
  localparam int FIFO_DEP  = 4;
  localparam int TMR_W     = 16;
  // Register addresses, one control pair per channel plus buffer and timer
  localparam logic [3:0] ADDR_CON1 = 4'h0;
  localparam logic [3:0] ADDR_CON2 = 4'h1;
  localparam logic [3:0] ADDR_BUF  = 4'h2;
  localparam logic [3:0] ADDR_TMR  = 4'h3;
  // Control one fields
  localparam int C1_IDLE   = 13;
  localparam int C1_CLK_LO = 10;
  localparam int C1_CPI_LO = 5;
  localparam int C1_OVF    = 4;
  localparam int C1_NE     = 3;
  // Control two fields
  localparam int C2_CAS    = 8;
  localparam int C2_TRIG   = 7;
  localparam int C2_RUN    = 6;
  // Reset values
  localparam logic [15:0] CON1_RST = 16'h0000;
  localparam logic [15:0] CON2_RST = 16'h000D;
  // Capture modes
  localparam logic [2:0] M_OFF  = 3'h0;
  localparam logic [2:0] M_BOTH = 3'h1;
  localparam logic [2:0] M_FALL = 3'h2;
  localparam logic [2:0] M_RISE = 3'h3;
  localparam logic [2:0] M_PS4  = 3'h4;
  localparam logic [2:0] M_PS16 = 3'h5;
  localparam logic [2:0] M_NONE = 3'h6;
  localparam logic [2:0] M_WAKE = 3'h7;
  // Timer clock selects
  localparam logic [2:0] CK_T3  = 3'h0;
  localparam logic [2:0] CK_T2  = 3'h1;
  localparam logic [2:0] CK_T4  = 3'h2;
  localparam logic [2:0] CK_T5  = 3'h3;
  localparam logic [2:0] CK_T1  = 3'h4;
  localparam logic [2:0] CK_PER = 3'h7;
  // Source select groups
  localparam logic [4:0] S_OC1  = 5'h01;
  localparam logic [4:0] S_IC1  = 5'h05;
  localparam logic [4:0] S_TM1  = 5'h0B;
  localparam logic [4:0] S_II1  = 5'h10;
  localparam logic [4:0] S_AN0  = 5'h16;
  localparam logic [4:0] S_CHG  = 5'h1C;
  // Prescale counts
  localparam logic [3:0] PS4_LAST  = 4'h3;
  localparam logic [3:0] PS16_LAST = 4'hF;
endpackage

// ===== icc_capture.sv
// Four-channel input capture block with timers, buffers and sync logic
//
// Function
// RULE_01: Four channels, own 16-bit timer, controls.
// RULE_02: Four-entry FIFO holds captured timer values.
// RULE_03: Modes 011 rise, 010 fall, 001 both.
// RULE_04: Mode 101 every 16th, 100 every 4th.
// RULE_05: Modes 000 and 110 disable channel.
// RULE_06: Mode 111 wake on rise only.
// RULE_07: Interrupt after every 1 to 4 captures.
// RULE_08: Count ignored in modes 001, 111.
// RULE_09: Overflow flag hardware-only, read-only.
// RULE_10: Not-empty flag shows unread data.
// RULE_11: Idle-stop bit halts channel in Idle.
// RULE_12: Clock select picks timer tick source.
// RULE_13: Both cascade bits pair into 32 bits.
// RULE_14: Software sets cascade in both channels.
// RULE_15: Trigger bit picks start versus sync.
// RULE_16: Trigger mode: run bit gates timer.
// RULE_17: Software reads, sets, clears run bit.
// RULE_18: Sync source resets to timer three.
// RULE_19: Codes 01011-01111 pick timers 1-5.
// RULE_20: Compare outputs; capture rollover next cycle.
// RULE_21: Capture interrupts; charge unit trigger code.
// RULE_22: Analog sources only for trigger mode.
// RULE_23: Never select own channel as source.
// RULE_24: Capture writes timer; full sets overflow.
//
// Register slots per channel, channel number in address bits 5:4:
//   index 0  control one: idle halt, clock select, decimation, mode
//   index 1  control two: cascade, trigger select, run bit, source
//   index 2  buffer head, a read pops it
//   index 3  timer value, read only
//   others   read as zero, writes dropped
//
// Timing:
//   a pin edge is resampled twice before the edge detector sees it,
//   so a capture lands about three clocks after the pin moves;
//   the interrupt pulse rises on the same clock as the buffer write.
//   Read data stand only in the cycle after the read strobe and are
//   zero otherwise, so several slaves can share one return bus.
//
// Status:
//   the not-empty flag is registered from the next buffer count, so
//   it already agrees with the buffer in the cycle after a push or pop;
//   overflow is set by a capture into a full buffer and cleared by the
//   next buffer read; when both fall in one cycle the set wins.
//
// Cascade:
//   the odd channel of a pair counts only on the even channel's wrap,
//   and only while both halves have their cascade bit set; a pair with
//   one bit set runs as two separate 16-bit channels.
//
// Limitations:
//   the buffer pops on any read of index 2, so a debugger that peeks
//   there consumes data;
//   a source that points at the channel itself is decoded anyway and
//   restarts the timer on its own wrap;
//   analog and converter sources are gated off in sync mode, since
//   their timing is too loose to line up two timers;
//   reading an empty buffer returns a stale entry, so software checks
//   the not-empty flag first.
//   Sleep halts every mode but the wake mode, which needs no timer.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module icc_capture
  import icc_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [5:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdata,
  // Capture pins, asynchronous
  input  wire logic [3:0]  capPin,
  // Power state
  input  wire logic        cpuIdle,
  input  wire logic        cpuSleep,
  // Tick enables of timers one to five
  input  wire logic [4:0]  timerTick,
  // External sync sources: compares, timers, analog, converter, charge unit
  input  wire logic [3:0]  compareEvt,
  input  wire logic [4:0]  timerEvt,
  input  wire logic [4:0]  analogEvt,
  input  wire logic        adcEvt,
  input  wire logic        chargeEvt,
  // Per-channel interrupt pulses
  output logic      [3:0]  capIrq
);
  import icc_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [2:0] cpiLast(input logic [1:0] c);
    cpiLast = {1'b0, c};
  endfunction
  // One channel's register slot on the port
  function automatic logic regHit(input logic [5:0] a, input logic [1:0] ch,
                                  input logic [3:0] idx);
    regHit = (a[5:4] == ch) && (a[3:0] == idx);
  endfunction
  // Timer at its last count before wrapping
  function automatic logic atTop(input logic [15:0] t);
    atTop = t == 16'hFFFF;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Storage
  logic [15:0] con1_r   [NUM_CH];
  logic [15:0] con2_r   [NUM_CH];
  logic [15:0] tmr_r    [NUM_CH];
  logic [15:0] fifo_r   [NUM_CH][FIFO_DEP];
  logic [1:0]  wrPtr_r  [NUM_CH];
  logic [1:0]  rdPtr_r  [NUM_CH];
  logic [2:0]  count_r  [NUM_CH];
  logic [3:0]  psCnt_r  [NUM_CH];
  logic [2:0]  evCnt_r  [NUM_CH];
  logic [3:0]  pinS1_r, pinS2_r, pinD_r;
  logic [3:0]  rollD_r;
  logic [3:0]  irqD_r;
  logic [15:0] rdData_r;
  logic [3:0]  rollEvt;
  logic [3:0]  capEvt;
  logic [3:0]  runWake;

  // Two-flop synchronizer, edge detect compares the second stage with its delayed copy
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pinS1_r <= 4'h0;
      pinS2_r <= 4'h0;
      pinD_r  <= 4'h0;
    end
    else
    begin
      pinS1_r <= capPin;
      pinS2_r <= pinS1_r;
      pinD_r  <= pinS2_r;
    end
  end

  wire [3:0] riseEdge = pinS2_r & ~pinD_r;
  wire [3:0] fallEdge = ~pinS2_r & pinD_r;
  wire [1:0] chSel    = regAddr[5:4];
  wire [3:0] regSel   = regAddr[3:0];

  //////////////////////////////////////////////////////////////////////////
  // Per-channel datapath
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : gCh
      localparam int PEER = g ^ 1;
      wire [2:0] mode    = con1_r[g][2:0];
      wire [2:0] clkSel  = con1_r[g][C1_CLK_LO +: 3];
      wire [1:0] cpi     = con1_r[g][C1_CPI_LO +: 2];
      wire [4:0] src     = con2_r[g][4:0];
      wire       trigMd  = con2_r[g][C2_TRIG];
      wire       running = con2_r[g][C2_RUN];
      // Cascade only when both halves agree
      wire       cascade = con2_r[g][C2_CAS] & con2_r[PEER][C2_CAS];  // RULE_13 RULE_14
      wire       isOdd   = (g % 2) == 1;
      wire       halted  = cpuSleep | (cpuIdle & con1_r[g][C1_IDLE]);  // RULE_11
      wire       active  = (mode != M_OFF) && (mode != M_NONE)
                           && (mode != M_WAKE) && !halted;             // RULE_05
      // Timer tick select; reserved codes never tick
      logic tick;
      always_comb
      begin
        case (clkSel)                                                  // RULE_12
          CK_PER:  tick = 1'b1;
          CK_T1:   tick = timerTick[0];
          CK_T2:   tick = timerTick[1];
          CK_T3:   tick = timerTick[2];
          CK_T4:   tick = timerTick[3];
          CK_T5:   tick = timerTick[4];
          default: tick = 1'b0;
        endcase
      end
      // Source select; own channel is a software error, still decoded
      logic srcEvt;
      always_comb
      begin
        srcEvt = 1'b0;
        if (src >= S_OC1 && src < S_IC1)                                // RULE_20
          srcEvt = compareEvt[2'(src - S_OC1)];
        else if (src >= S_IC1 && src < S_IC1 + 5'h04)                   // RULE_20 RULE_23
          srcEvt = rollD_r[2'(src - S_IC1)];
        else if (src >= S_TM1 && src < S_TM1 + 5'h05)                   // RULE_19 RULE_18
          srcEvt = timerEvt[3'(src - S_TM1)];
        else if (src >= S_II1 && src < S_II1 + 5'h04)                   // RULE_21
          srcEvt = irqD_r[2'(src - S_II1)];
        else if (src >= S_AN0 && src < S_AN0 + 5'h05)                   // RULE_22
          srcEvt = trigMd & analogEvt[3'(src - S_AN0)];
        else if (src == S_AN0 + 5'h05)                                  // RULE_22
          srcEvt = trigMd & adcEvt;
        else if (src == S_CHG)                                          // RULE_21
          srcEvt = chargeEvt;
      end
      // Own count enable: tick, channel live, not held by trigger
      wire incrLow  = tick && active && (!trigMd || running);
      // The upper half of a cascade counts on the lower half's carry
      wire incr     = (cascade && isOdd) ? atTop(tmr_r[PEER]) && gCh[PEER].incrLow
                                         : tick;
      assign rollEvt[g] = incrLow && atTop(tmr_r[g]);
      // Edge qualification by mode
      logic edgeHit;
      always_comb
      begin
        case (mode)                                                    // RULE_03 RULE_04
          M_BOTH:  edgeHit = riseEdge[g] | fallEdge[g];
          M_FALL:  edgeHit = fallEdge[g];
          M_RISE:  edgeHit = riseEdge[g];
          M_PS4:   edgeHit = riseEdge[g] && (psCnt_r[g] == PS4_LAST);
          M_PS16:  edgeHit = riseEdge[g] && (psCnt_r[g] == PS16_LAST);
          default: edgeHit = 1'b0;
        endcase
      end
      assign capEvt[g]  = edgeHit && active;
      assign runWake[g] = (mode == M_WAKE) && (cpuSleep | cpuIdle) && riseEdge[g];  // RULE_06
      // Buffer strobes; a pop of an empty buffer is ignored
      wire   full       = count_r[g] == 3'(FIFO_DEP);
      wire   popReq     = regRd && regHit(regAddr, 2'(g), ADDR_BUF);
      wire   doPop      = popReq && (count_r[g] != 3'h0);
      wire   doPush     = capEvt[g] && !full;
      wire   cpiHit     = (mode == M_BOTH) || (evCnt_r[g] == cpiLast(cpi)); // RULE_07 RULE_08
      wire   wrCon1     = regWr && regHit(regAddr, 2'(g), ADDR_CON1);
      wire   wrCon2     = regWr && regHit(regAddr, 2'(g), ADDR_CON2);
      // Timer enables
      wire   tmrZero    = trigMd && !running;
      wire   tmrNxtInc  = cascade && isOdd ? incr : incrLow;

      // Control registers; status bits not writable by software
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          con1_r[g] <= CON1_RST;
          con2_r[g] <= CON2_RST;                                       // RULE_18
        end
        else
        begin
          if (wrCon1)
          begin
            con1_r[g][C1_IDLE]          <= regWdata[C1_IDLE];
            con1_r[g][C1_CLK_LO +: 3]   <= regWdata[C1_CLK_LO +: 3];
            con1_r[g][C1_CPI_LO +: 2]   <= regWdata[C1_CPI_LO +: 2];
            con1_r[g][2:0]              <= regWdata[2:0];
          end
          con1_r[g][C1_NE]  <= (count_r[g] != 3'h0 || doPush)
                               && !(count_r[g] == 3'h1 && doPop && !doPush); // RULE_10
          // Overflow set on push into full, cleared by the next pop
          if (capEvt[g] && full)
            con1_r[g][C1_OVF] <= 1'b1;                                 // RULE_09 RULE_24
          else if (doPop)
            con1_r[g][C1_OVF] <= 1'b0;                                 // RULE_09
          if (wrCon2)
          begin
            con2_r[g][15:9]    <= 7'h00;
            con2_r[g][C2_CAS]  <= regWdata[C2_CAS];
            con2_r[g][C2_TRIG] <= regWdata[C2_TRIG];
            con2_r[g][C2_RUN]  <= regWdata[C2_RUN];                    // RULE_17
            con2_r[g][5]       <= 1'b0;
            con2_r[g][4:0]     <= regWdata[4:0];
          end
          // Hardware set wins over a software clear
          if (trigMd && srcEvt)
            con2_r[g][C2_RUN] <= 1'b1;                                 // RULE_16
        end
      end

      // Timer: sync clears it, trigger gates it
      // Zero hold outranks sync, which outranks counting
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
          tmr_r[g] <= 16'h0000;
        else if (tmrZero)
          tmr_r[g] <= 16'h0000;                                        // RULE_16
        else if (!trigMd && srcEvt)
          tmr_r[g] <= 16'h0000;                                        // RULE_15
        else if (tmrNxtInc && active)
          tmr_r[g] <= tmr_r[g] + 16'h0001;                             // RULE_01
      end

      // Buffer, prescaler and interrupt decimation
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          wrPtr_r[g] <= 2'h0;
          rdPtr_r[g] <= 2'h0;
          count_r[g] <= 3'h0;
          psCnt_r[g] <= 4'h0;
          evCnt_r[g] <= 3'h0;
          for (int k = 0; k < FIFO_DEP; k++)
            fifo_r[g][k] <= 16'h0000;
        end
        else
        begin
          if (doPush)
          begin
            fifo_r[g][wrPtr_r[g]] <= tmr_r[g];                         // RULE_02 RULE_24
            wrPtr_r[g] <= wrPtr_r[g] + 2'h1;
          end
          if (doPop)
            rdPtr_r[g] <= rdPtr_r[g] + 2'h1;
          count_r[g] <= count_r[g] + 3'(doPush) - 3'(doPop);
          // Prescaler restarts whenever the channel is idle
          if (!active)
            psCnt_r[g] <= 4'h0;
          else if (riseEdge[g])
            psCnt_r[g] <= ((mode == M_PS4) && psCnt_r[g] == PS4_LAST) ? 4'h0
                          : psCnt_r[g] + 4'h1;                         // RULE_04
          if (!active)
            evCnt_r[g] <= 3'h0;
          else if (capEvt[g])
            evCnt_r[g] <= cpiHit ? 3'h0 : evCnt_r[g] + 3'h1;           // RULE_07
        end
      end
      // Cause is registered below for a clean one-cycle pulse
      assign capIrq[g] = irqD_r[g];
      wire irqNow = (capEvt[g] && cpiHit) || runWake[g];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Interrupt and rollover registers; rollover acts one cycle later
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      irqD_r  <= 4'h0;
      rollD_r <= 4'h0;
    end
    else
    begin
      irqD_r  <= {gCh[3].irqNow, gCh[2].irqNow, gCh[1].irqNow, gCh[0].irqNow};
      rollD_r <= rollEvt;                                              // RULE_20
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read decode; buffer read returns head entry
  // The pop itself happens in the channel logic on the same strobe,
  // so the head is captured here before the pointer moves
  logic [15:0] rdMux;
  always_comb
  begin
    case (regSel)
      ADDR_CON1: rdMux = con1_r[chSel];
      ADDR_CON2: rdMux = con2_r[chSel];
      ADDR_BUF:  rdMux = fifo_r[chSel][rdPtr_r[chSel]];
      ADDR_TMR:  rdMux = tmr_r[chSel];
      default:   rdMux = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rdData_r <= 16'h0000;
    else if (regRd)
      rdData_r <= rdMux;
    else
      rdData_r <= 16'h0000;
  end
  assign regRdata = rdData_r;

endmodule // icc_capture

// ===== icc_capture_monitor.sv
// Port checker for the capture block
`timescale 1ns/1ns
module icc_capture_monitor
  import icc_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [5:0]  regAddr,
  input  wire logic        regRd,
  input  wire logic [15:0] regRdata,
  // Pins and interrupts
  input  wire logic [3:0]  capPin,
  input  wire logic [3:0]  capIrq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Read decode
  wire rdOne = regRd && regAddr[3:0] == ADDR_CON1;
  wire rdTwo = regRd && regAddr[3:0] == ADDR_CON2;
  wire rdOff = regRd && regAddr[3:0] > ADDR_TMR;
  logic [3:0] pinPrev_r;
  logic [3:0] quietCnt_r;
  logic [3:0] quietCnt_nxt;
  // Cycles since the last pin change, saturating
  assign quietCnt_nxt = (capPin != pinPrev_r) ? 4'h0 :
                        (quietCnt_r == 4'hF) ? quietCnt_r : quietCnt_r + 4'h1;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      pinPrev_r  <= 4'h0;
      quietCnt_r <= 4'hF;
    end
    else
    begin
      pinPrev_r  <= capPin;
      quietCnt_r <= quietCnt_nxt;
    end
  ////////////////////////////////////////
  property p_rdZero; !$past(regRd) |-> regRdata == 16'h0000; endproperty
  a_rdZero: assert property (p_rdZero) else $error("read data outside slot");
  property p_unmap; rdOff |=> regRdata == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_con1; rdOne |=> regRdata[15:14] == 2'h0 && regRdata[9:7] == 3'h0; endproperty
  a_con1: assert property (p_con1) else $error("control one spare bits set");
  property p_con2; rdTwo |=> regRdata[15:9] == 7'h00 && !regRdata[5]; endproperty
  a_con2: assert property (p_con2) else $error("control two spare bits set");
  property p_ovfNe; rdOne |=> !regRdata[C1_OVF] || regRdata[C1_NE]; endproperty
  a_ovfNe: assert property (p_ovfNe) else $error("overflow with empty buffer");
  property p_irqPulse; capIrq[0] |=> !capIrq[0]; endproperty
  a_irqPulse: assert property (p_irqPulse) else $error("interrupt longer than a cycle");
  property p_irqCause; capIrq != 4'h0 |-> quietCnt_r <= 4'h8; endproperty
  a_irqCause: assert property (p_irqCause) else $error("interrupt without pin edge");
  property p_rstQuiet; $fell(rst) |-> (capIrq == 4'h0) [*3]; endproperty
  a_rstQuiet: assert property (p_rstQuiet) else $error("interrupt right after reset");
endmodule // icc_capture_monitor
bind icc_capture icc_capture_monitor u_mon (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
  .regRd(regRd), .regRdata(regRdata), .capPin(capPin), .capIrq(capIrq));

// ===== icc_pin_src.sv
// Model of the capture pin source and the free-running timers
`timescale 1ns/1ns
module icc_pin_src
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Pulse request
  input  wire logic [4:0] pulseNum,
  input  wire logic       pulseGo,
  // Toward the block
  output logic      [3:0] capPin,
  output logic      [4:0] timerTick,
  output logic            pulseBusy
);
  logic [2:0] tickDiv_r;
  // Timers run free; timers one and five both tick once in eight cycles
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      tickDiv_r <= 3'h0;
    else
      tickDiv_r <= tickDiv_r + 3'h1;
  assign timerTick = {tickDiv_r == 3'h7, tickDiv_r[1:0] == 2'h0, tickDiv_r[0], 1'b1,
                      tickDiv_r == 3'h0};
  ////////////////////////////////////////
  // Pulses 4 high, 4 low, moved off the edge since the pin is asynchronous
  initial
  begin
    capPin = 4'h0;
    pulseBusy = 1'b0;
    forever
    begin
      @(posedge sys_clk iff pulseGo);
      pulseBusy = 1'b1;
      repeat (pulseNum)
      begin
        repeat (4) @(posedge sys_clk);
        #3 capPin[0] = 1'b1;
        repeat (4) @(posedge sys_clk);
        #3 capPin[0] = 1'b0;
      end
      pulseBusy = 1'b0;
    end
  end
endmodule // icc_pin_src

// ===== icc_capture_tb_top.sv
// Self-checking bench for the capture block
`timescale 1ns/1ns
module icc_capture_tb_top;
  import icc_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, pulseGo = 1'b0;
  logic cpuIdle = 1'b0, cpuSleep = 1'b0, pulseBusy;
  logic [5:0] regAddr = 6'h00;
  logic [15:0] regWdata = 16'h0000, regRdata, v, w;
  logic [4:0] timerEvt = 5'h00, pulseNum = 5'h00, timerTick;
  logic [3:0] capPin, capIrq;
  int num_errors = 0, tests_run = 0, irqCnt = 0, cycles = 0, n;
  logic [2:0] modeTab [7] = '{M_RISE, M_FALL, M_BOTH, M_OFF, M_NONE, M_PS4, M_PS16};
  int pulseTab [7] = '{2, 2, 2, 2, 2, 8, 16};
  int capTab [7] = '{2, 2, 4, 0, 0, 2, 1};
  localparam logic [15:0] PER = 16'(CK_PER) << C1_CLK_LO;
  icc_capture uut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .capPin(capPin), .cpuIdle(cpuIdle),
    .cpuSleep(cpuSleep), .timerTick(timerTick), .compareEvt(4'h0), .timerEvt(timerEvt),
    .analogEvt(5'h00), .adcEvt(1'b0), .chargeEvt(1'b0), .capIrq(capIrq));
  icc_pin_src u_src (.sys_clk(sys_clk), .rst(rst), .pulseNum(pulseNum), .pulseGo(pulseGo),
    .capPin(capPin), .timerTick(timerTick), .pulseBusy(pulseBusy));
  // Clock, interrupt tally and hang guard
  initial
    forever #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    irqCnt += (capIrq[0] === 1'b1);
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  ////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (s !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      num_errors++;
    end
  endtask
  // Bus cycles, one strobe cycle each
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= {2'h0, a};
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= {2'h0, a};
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic pulses(input int k);
    @(posedge sys_clk);
    pulseNum <= 5'(k);
    pulseGo <= 1'b1;
    @(posedge sys_clk);
    pulseGo <= 1'b0;
    @(posedge sys_clk iff !pulseBusy);
    repeat (8) @(posedge sys_clk);
  endtask
  // Pops the buffer until empty; n counts the values
  task automatic drain();
    n = 0;
    rd(ADDR_CON1, v);
    while (v[C1_NE] === 1'b1 && n < 8)
    begin
      rd(ADDR_BUF, w);
      n++;
      rd(ADDR_CON1, v);
    end
  endtask
  ////////////////////////////////////////
  task automatic t_modes();
    for (int i = 0; i < 7; i++)
    begin
      wr(ADDR_CON1, PER | modeTab[i]);
      irqCnt = 0;
      pulses(pulseTab[i]);
      drain();
      chk("captures", 16'(capTab[i]), 16'(n));
      chk("irqs", 16'(capTab[i]), 16'(irqCnt));
      wr(ADDR_CON1, 16'h0000);
    end
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_CON1, PER | 16'(c) << C1_CPI_LO | M_RISE);
      irqCnt = 0;
      pulses(4);
      drain();
      chk("cpi irqs", 16'(4 / (c + 1)), 16'(irqCnt));
      wr(ADDR_CON1, 16'h0000);
    end
    $display("done modes");
  endtask
  task automatic t_ovf();
    wr(ADDR_CON1, PER | M_RISE);
    pulses(5);
    wr(ADDR_CON1, PER | M_RISE);
    rd(ADDR_CON1, v);
    chk("ovf ne", 16'h0003, 16'(v[4:3]));
    rd(ADDR_BUF, v);
    rd(ADDR_BUF, w);
    chk("spacing", 16'h0008, w - v);
    rd(ADDR_CON1, v);
    chk("ovf clear", 16'h0000, 16'(v[C1_OVF]));
    drain();
    chk("kept", 16'h0002, 16'(n));
    chk("empty", 16'h0000, 16'(v[C1_NE]));
    $display("done overflow");
  endtask
  task automatic t_power();
    cpuIdle <= 1'b1;
    wr(ADDR_CON1, 16'h1 << C1_IDLE | PER | M_RISE);
    pulses(2);
    drain();
    chk("idle halt", 16'h0000, 16'(n));
    wr(ADDR_CON1, PER | M_RISE);
    pulses(1);
    drain();
    chk("idle run", 16'h0001, 16'(n));
    cpuIdle <= 1'b0;
    cpuSleep <= 1'b1;
    wr(ADDR_CON1, 16'h3 << C1_CPI_LO | M_WAKE);
    irqCnt = 0;
    pulses(2);
    chk("wake irqs", 16'h0002, 16'(irqCnt));
    cpuSleep <= 1'b0;
    wr(ADDR_CON1, 16'h0000);
    drain();
    $display("done power");
  endtask
  task automatic t_trig();
    wr(ADDR_CON1, PER | M_RISE);
    wr(ADDR_CON2, 16'h1 << C2_TRIG | S_TM1);
    rd(ADDR_TMR, v);
    chk("held", 16'h0000, v);
    @(posedge sys_clk);
    timerEvt <= 5'h01;
    @(posedge sys_clk);
    timerEvt <= 5'h00;
    rd(ADDR_CON2, v);
    chk("run bit", 16'h0001, 16'(v[C2_RUN]));
    rd(ADDR_TMR, v);
    rd(ADDR_TMR, w);
    chk("tmr step", 16'h0002, w - v);
    wr(ADDR_CON2, 16'h1 << C2_TRIG | S_TM1);
    rd(ADDR_TMR, v);
    chk("sw clear", 16'h0000, v);
    $display("done trigger");
  endtask
  task automatic t_sync();
    wr(ADDR_CON2, 16'h1 << C2_CAS | S_TM1);
    rd(ADDR_TMR, v);
    rd(ADDR_TMR, w);
    chk("lone cascade", 16'h0002, w - v);
    @(posedge sys_clk);
    timerEvt <= 5'h01;
    @(posedge sys_clk);
    timerEvt <= 5'h00;
    rd(ADDR_TMR, v);
    chk("sync clear", 16'h0001, v);
    wr(ADDR_CON1, 16'(CK_T3) << C1_CLK_LO | M_RISE);
    rd(ADDR_TMR, v);
    rd(ADDR_TMR, w);
    chk("half rate", 16'h0001, w - v);
    $display("done sync");
  endtask
  // Main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    rd(ADDR_CON1, v);
    chk("con1 reset", CON1_RST, v);
    rd(ADDR_CON2, v);
    chk("con2 reset", CON2_RST, v);
    rd(4'h9, v);
    chk("unmapped", 16'h0000, v);
    t_modes();
    t_ovf();
    t_power();
    t_trig();
    t_sync();
    print_verdict();
  end
endmodule // icc_capture_tb_top
